// ===== csf_consts.vh
// Register offsets, field positions and reset values of the serial port
`ifndef CSF_CONSTS_VH
`define CSF_CONSTS_VH
`define CSF_ADDR_W 4
`define CSF_OFF_RXDATA 4'h0
`define CSF_OFF_TXDATA 4'h1
`define CSF_OFF_MODE 4'h2
`define CSF_OFF_CTRL 4'h3
`define CSF_OFF_STAT 4'h4
`define CSF_OFF_BRR 4'h5
`define CSF_OFF_PIN 4'h6
`define CSF_OFF_FCR 4'h7
`define CSF_OFF_FDR 4'h8
`define CSF_OFF_LSR 4'h9
`define CSF_BRR_RST 8'hFF
`define CSF_MODE_RST 16'h0000
`define CSF_CTRL_RST 16'h0000
`define CSF_PIN_RST 16'h0000
`define CSF_FCR_RST 16'h0000
`define CSF_FCR_RFRST 0
`define CSF_FCR_TFRST 1
`define CSF_FCR_LOOP 2
`define CSF_FCR_RTRG_LO 3
`define CSF_FCR_RTRG_HI 6
`define CSF_FCR_TTRG_LO 7
`define CSF_FCR_TTRG_HI 10
`define CSF_CTRL_RE 0
`define CSF_CTRL_TE 1
`define CSF_CTRL_CKE 2
`define CSF_CTRL_RIE 3
`define CSF_CTRL_TIE 4
`define CSF_CTRL_REIE 5
`define CSF_MODE_CKS_LO 0
`define CSF_MODE_CKS_HI 1
`define CSF_ST_DR 0
`define CSF_ST_RDF 1
`define CSF_ST_PER 2
`define CSF_ST_FER 3
`define CSF_ST_BRK 4
`define CSF_ST_TX_FIFO_LOW_FLAG 5
`define CSF_ST_TX_DONE_FLAG 6
`define CSF_ST_ER 7
`define CSF_PIN_TXD_DATA 0
`define CSF_PIN_TXD_EN 1
`define CSF_PIN_SCK_DATA 2
`define CSF_PIN_SCK_EN 3
`define CSF_PIN_CTS_DATA 4
`define CSF_PIN_CTS_EN 5
`define CSF_PIN_RTS_DATA 6
`define CSF_PIN_RTS_EN 7
`define CSF_FIFO_DEPTH 16
`define CSF_IDLE_BITS 8'h08
`endif

// ===== csf_fifo_mem.v
// Byte memory for one FIFO with registered read data
`timescale 1ns/100ps
`default_nettype none
module csf_fifo_mem #(
  parameter DW = 8,
  parameter AW = 4
) (
  input wire ref_clk_i,
  input wire wr_en_i,
  input wire [AW-1:0] wr_addr_i,
  input wire [DW-1:0] wr_data_i,
  input wire [AW-1:0] rd_addr_i,
  output reg [DW-1:0] rd_data_o
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  always @(posedge ref_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule
`default_nettype wire

// ===== csf_serial_port.v
// Clock-synchronous serial port with transmit and receive FIFOs
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "csf_consts.vh"
module csf_serial_port #(
  parameter DEPTH = `CSF_FIFO_DEPTH
) (
  input wire ref_clk_i,
  input wire srst_i,
  input wire [`CSF_ADDR_W-1:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  input wire rxd_i,
  output reg txd_o,
  input wire sck_i,
  output reg sck_o,
  output reg sck_oe_o,
  output reg rts_n_o,
  input wire cts_n_i,
  output reg txi_o,
  output reg rxi_o,
  output reg bri_o,
  output reg eri_o
);
  localparam AW = 4;
  localparam [4:0] FULL = DEPTH[4:0];
  // ***************************************
  // Registers
  // ***************************************
  reg [15:0] mode_ff, ctrl_ff, pin_ff, fcr_ff;
  reg [7:0] brr_ff;
  reg [7:0] flag_ff;
  reg [7:0] flag_seen_ff;
  reg overrun_flag_ff, overrun_flag_seen_ff;
  reg [4:0] tcnt_ff, rcnt_ff;
  reg [AW-1:0] twp_ff, trp_ff, rwp_ff, rrp_ff;
  reg [7:0] tsr_ff, rsr_ff;
  reg [3:0] tbit_ff, rbit_ff;
  reg tbusy_ff;
  reg t_ready_ff;
  reg [7:0] brg_cnt_ff;
  reg [5:0] pre_cnt_ff;
  reg sck_int_ff;
  reg [2:0] rxd_s_ff, sck_s_ff, cts_s_ff;
  reg [7:0] idle_cnt_ff;
  wire [7:0] tmem_q, rmem_q;
  // ***************************************
  // Pin synchronisers
  // ***************************************
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      rxd_s_ff <= 3'h7;
      sck_s_ff <= 3'h7;
      cts_s_ff <= 3'h7;
    end else begin
      rxd_s_ff <= {rxd_s_ff[1:0], rxd_i};
      sck_s_ff <= {sck_s_ff[1:0], sck_i};
      cts_s_ff <= {cts_s_ff[1:0], cts_n_i};
    end
  end
  wire ext_clk = ~ctrl_ff[`CSF_CTRL_CKE];
  wire loop = fcr_ff[`CSF_FCR_LOOP];
  // ***************************************
  // Bit-rate generator
  // ***************************************
  function pre_hit;
    input [1:0] cks;
    input [5:0] cnt;
    begin
      case (cks)
        2'h0: pre_hit = 1'b1;
        2'h1: pre_hit = (cnt[1:0] == 2'h3);
        2'h2: pre_hit = (cnt[3:0] == 4'hF);
        default: pre_hit = (cnt == 6'h3F);
      endcase
    end
  endfunction
  wire pre_tick = pre_hit(mode_ff[`CSF_MODE_CKS_HI:`CSF_MODE_CKS_LO], pre_cnt_ff);
  wire brg_tick = pre_tick && (brg_cnt_ff == 8'h00);
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      pre_cnt_ff <= 6'h00;
      brg_cnt_ff <= 8'h00;
      sck_int_ff <= 1'b1;
    end else begin
      pre_cnt_ff <= pre_cnt_ff + 6'h01;
      if (pre_tick) begin
        brg_cnt_ff <= (brg_cnt_ff == 8'h00) ? brr_ff : brg_cnt_ff - 8'h01;
      end
      if (brg_tick) begin
        sck_int_ff <= (tbusy_ff || sck_int_ff == 1'b0) ? ~sck_int_ff : 1'b1;
      end
    end
  end
  // Edges of the shift clock, internal or external
  reg sck_prev_ff;
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      sck_prev_ff <= 1'b1;
    end else begin
      sck_prev_ff <= ext_clk ? sck_s_ff[1] : sck_int_ff;
    end
  end
  wire sck_now = ext_clk ? sck_s_ff[1] : sck_int_ff;
  wire fall = sck_prev_ff && !sck_now;
  wire rise = !sck_prev_ff && sck_now;
  // Only the second synchroniser stage feeds logic
  wire rx_bit = loop ? txd_o : rxd_s_ff[1];
  // ***************************************
  // Bus decode
  // ***************************************
  wire wr_tx = wr_i && addr_i == `CSF_OFF_TXDATA;
  wire rd_rx = rd_i && addr_i == `CSF_OFF_RXDATA;
  wire wr_fcr = wr_i && addr_i == `CSF_OFF_FCR;
  wire t_rst = fcr_ff[`CSF_FCR_TFRST];
  wire r_rst = fcr_ff[`CSF_FCR_RFRST];
  wire t_push = wr_tx && tcnt_ff != FULL && !t_rst;
  // Head entry must be one cycle old so the registered read data are fresh
  wire t_pop = ctrl_ff[`CSF_CTRL_TE] && !tbusy_ff && t_ready_ff && tcnt_ff != 5'h00
    && !t_rst;
  wire r_done = ctrl_ff[`CSF_CTRL_RE] && rise && rbit_ff == 4'h7;
  wire r_push = r_done && rcnt_ff != FULL && !r_rst;
  wire r_drop = r_done && rcnt_ff == FULL;
  wire r_pop = rd_rx && rcnt_ff != 5'h00 && !r_rst;
  wire [7:0] rx_byte = {rx_bit, rsr_ff[7:1]};
  csf_fifo_mem #(.DW(8), .AW(AW)) u_tmem (
    .ref_clk_i(ref_clk_i),
    .wr_en_i(t_push),
    .wr_addr_i(twp_ff),
    .wr_data_i(wdata_i[7:0]),
    .rd_addr_i(t_pop ? trp_ff + 4'h1 : trp_ff),
    .rd_data_o(tmem_q)
  );
  csf_fifo_mem #(.DW(8), .AW(AW)) u_rmem (
    .ref_clk_i(ref_clk_i),
    .wr_en_i(r_push),
    .wr_addr_i(rwp_ff),
    .wr_data_i(rx_byte),
    .rd_addr_i(r_pop ? rrp_ff + 4'h1 : rrp_ff),
    .rd_data_o(rmem_q)
  );
  // ***************************************
  // FIFO pointers and counts
  // ***************************************
  always @(posedge ref_clk_i) begin
    if (srst_i || t_rst) begin
      twp_ff <= 4'h0;
      trp_ff <= 4'h0;
      t_ready_ff <= 1'b0;
      tcnt_ff <= 5'h00;
    end else begin
      t_ready_ff <= (tcnt_ff != 5'h00);
      if (t_push) twp_ff <= twp_ff + 4'h1;
      if (t_pop) trp_ff <= trp_ff + 4'h1;
      tcnt_ff <= tcnt_ff + {4'h0, t_push} - {4'h0, t_pop};
    end
  end
  always @(posedge ref_clk_i) begin
    if (srst_i || r_rst) begin
      rwp_ff <= 4'h0;
      rrp_ff <= 4'h0;
      rcnt_ff <= 5'h00;
    end else begin
      if (r_push) rwp_ff <= rwp_ff + 4'h1;
      if (r_pop) rrp_ff <= rrp_ff + 4'h1;
      rcnt_ff <= rcnt_ff + {4'h0, r_push} - {4'h0, r_pop};
    end
  end
  // ***************************************
  // Shift stages
  // ***************************************
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      tsr_ff <= 8'h00;
      tbit_ff <= 4'h0;
      tbusy_ff <= 1'b0;
      rsr_ff <= 8'h00;
      rbit_ff <= 4'h0;
    end else begin
      if (t_pop) begin
        tbusy_ff <= 1'b1;
        tbit_ff <= 4'h0;
        tsr_ff <= tmem_q;
      end else if (tbusy_ff && fall && tbit_ff != 4'h0) begin
        // First fall keeps bit 0; each later fall presents the next bit
        tsr_ff <= {1'b1, tsr_ff[7:1]};
      end else if (tbusy_ff && rise) begin
        // Byte ends on the eighth rise, so no extra clock edge follows except at CKS 0 with brr_ff 0, where one more fall and rise come
        tbit_ff <= tbit_ff + 4'h1;
        if (tbit_ff == 4'h7) begin
          tbusy_ff <= 1'b0;
        end
      end
      if (!ctrl_ff[`CSF_CTRL_RE]) begin
        rbit_ff <= 4'h0;
      end else if (rise) begin
        rsr_ff <= rx_byte;
        rbit_ff <= (rbit_ff == 4'h7) ? 4'h0 : rbit_ff + 4'h1;
      end
    end
  end
  // ***************************************
  // Status flags
  // ***************************************
  wire [7:0] set_flag;
  assign set_flag[`CSF_ST_DR] = (idle_cnt_ff == `CSF_IDLE_BITS) && rcnt_ff != 5'h00;
  assign set_flag[`CSF_ST_RDF] = rcnt_ff >= {1'b0, fcr_ff[`CSF_FCR_RTRG_HI:`CSF_FCR_RTRG_LO]}
    && rcnt_ff != 5'h00;
  assign set_flag[`CSF_ST_PER] = 1'b0;
  assign set_flag[`CSF_ST_FER] = 1'b0;
  assign set_flag[`CSF_ST_BRK] = 1'b0;
  assign set_flag[`CSF_ST_TX_FIFO_LOW_FLAG] = tcnt_ff <= {1'b0, fcr_ff[`CSF_FCR_TTRG_HI:`CSF_FCR_TTRG_LO]};
  assign set_flag[`CSF_ST_TX_DONE_FLAG] = !tbusy_ff && tcnt_ff == 5'h00;
  assign set_flag[`CSF_ST_ER] = 1'b0;
  wire rd_st = rd_i && addr_i == `CSF_OFF_STAT;
  wire wr_st = wr_i && addr_i == `CSF_OFF_STAT;
  wire rd_ls = rd_i && addr_i == `CSF_OFF_LSR;
  wire wr_ls = wr_i && addr_i == `CSF_OFF_LSR;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_flag
      always @(posedge ref_clk_i) begin
        if (srst_i || g == `CSF_ST_PER || g == `CSF_ST_FER) begin
          flag_ff[g] <= 1'b0;
          flag_seen_ff[g] <= 1'b0;
        end else if (set_flag[g]) begin
          flag_ff[g] <= 1'b1;
        end else if (wr_st && !wdata_i[g] && flag_seen_ff[g]) begin
          flag_ff[g] <= 1'b0;
          flag_seen_ff[g] <= 1'b0;
        end else if (rd_st && flag_ff[g]) begin
          flag_seen_ff[g] <= 1'b1;
        end
      end
    end
  endgenerate
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      overrun_flag_ff <= 1'b0;
      overrun_flag_seen_ff <= 1'b0;
    end else if (r_drop) begin
      overrun_flag_ff <= 1'b1;
    end else if (wr_ls && !wdata_i[0] && overrun_flag_seen_ff) begin
      overrun_flag_ff <= 1'b0;
      overrun_flag_seen_ff <= 1'b0;
    end else if (rd_ls && overrun_flag_ff) begin
      overrun_flag_seen_ff <= 1'b1;
    end
  end
  always @(posedge ref_clk_i) begin
    if (srst_i || r_push || r_pop) begin
      idle_cnt_ff <= 8'h00;
    end else if (rise && idle_cnt_ff != `CSF_IDLE_BITS) begin
      idle_cnt_ff <= idle_cnt_ff + 8'h01;
    end
  end
  // ***************************************
  // Register writes and reads
  // ***************************************
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      mode_ff <= `CSF_MODE_RST;
      ctrl_ff <= `CSF_CTRL_RST;
      brr_ff <= `CSF_BRR_RST;
      pin_ff <= `CSF_PIN_RST;
      fcr_ff <= `CSF_FCR_RST;
    end else if (wr_i) begin
      if (addr_i == `CSF_OFF_MODE) mode_ff <= wdata_i;
      if (addr_i == `CSF_OFF_CTRL) ctrl_ff <= wdata_i;
      if (addr_i == `CSF_OFF_BRR) brr_ff <= wdata_i[7:0];
      if (addr_i == `CSF_OFF_PIN) pin_ff <= wdata_i;
      if (wr_fcr) fcr_ff <= wdata_i;
    end
  end
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      case (addr_i)
        `CSF_OFF_RXDATA: rdata_o <= {8'h00, rmem_q};
        `CSF_OFF_MODE: rdata_o <= mode_ff;
        `CSF_OFF_CTRL: rdata_o <= ctrl_ff;
        `CSF_OFF_STAT: rdata_o <= {8'h00, flag_ff};
        `CSF_OFF_BRR: rdata_o <= {8'h00, brr_ff};
        `CSF_OFF_PIN: rdata_o <= {pin_ff[15:5], cts_s_ff[1], sck_s_ff[1], pin_ff[2], rxd_s_ff[1],
          pin_ff[0]};
        `CSF_OFF_FCR: rdata_o <= fcr_ff;
        `CSF_OFF_FDR: rdata_o <= {3'h0, tcnt_ff, 3'h0, rcnt_ff};
        `CSF_OFF_LSR: rdata_o <= {15'h0000, overrun_flag_ff};
        default: rdata_o <= 16'h0000;
      endcase
    end else begin
      rdata_o <= 16'h0000;
    end
  end
  // ***************************************
  // Pins and requests
  // ***************************************
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      txd_o <= 1'b1;
      sck_o <= 1'b1;
      sck_oe_o <= 1'b0;
      rts_n_o <= 1'b1;
      txi_o <= 1'b0;
      rxi_o <= 1'b0;
      bri_o <= 1'b0;
      eri_o <= 1'b0;
    end else begin
      if (!ctrl_ff[`CSF_CTRL_TE]) txd_o <= pin_ff[`CSF_PIN_TXD_DATA];
      else if (tbusy_ff) txd_o <= tsr_ff[0];
      else txd_o <= 1'b1;
      sck_o <= ctrl_ff[`CSF_CTRL_CKE] ? sck_int_ff : pin_ff[`CSF_PIN_SCK_DATA];
      sck_oe_o <= ctrl_ff[`CSF_CTRL_CKE] || pin_ff[`CSF_PIN_SCK_EN];
      rts_n_o <= pin_ff[`CSF_PIN_RTS_EN] ? pin_ff[`CSF_PIN_RTS_DATA] : (rcnt_ff == FULL);
      txi_o <= ctrl_ff[`CSF_CTRL_TIE] && flag_ff[`CSF_ST_TX_FIFO_LOW_FLAG];
      rxi_o <= ctrl_ff[`CSF_CTRL_RIE] && (flag_ff[`CSF_ST_RDF] || flag_ff[`CSF_ST_DR]);
      bri_o <= ctrl_ff[`CSF_CTRL_REIE] && (overrun_flag_ff || flag_ff[`CSF_ST_BRK]);
      eri_o <= ctrl_ff[`CSF_CTRL_REIE] && flag_ff[`CSF_ST_ER];
    end
  end
endmodule
`default_nettype wire

// ===== csf_serial_port_assertions.sv
// Concurrent checks on the serial port register bus and pins
`timescale 1ns/100ps
`default_nettype none
module csf_serial_port_chk (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic txd_o,
  input wire logic sck_o,
  input wire logic sck_oe_o,
  input wire logic rts_n_o
);
  logic [15:0] last_wd;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  // ****************************************
  // Helper: last written data
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (wr_i) begin
      last_wd <= wdata_i;
    end
  end
  a_rdata_idle_zero: assert property (
    !$past(rd_i) |-> rdata_o == 16'h0000) else $error("read data not zero when idle");
  a_reset_pin_levels: assert property (
    $fell(srst_i) |-> txd_o && sck_o && !sck_oe_o && rts_n_o) else $error("bad pins after reset");
  a_unmapped_reads_zero: assert property (
    rd_i && addr_i > 4'h9 |=> rdata_o == 16'h0000) else $error("unmapped read not zero");
  a_rate_reg_echo: assert property (
    wr_i && addr_i == 4'h5 ##1 !wr_i ##1 rd_i && addr_i == 4'h5
    |=> rdata_o == {8'h00, last_wd[7:0]}) else $error("rate divisor readback wrong");
  a_ctrl_reg_echo: assert property (
    wr_i && addr_i == 4'h3 ##1 !wr_i ##1 rd_i && addr_i == 4'h3
    |=> rdata_o[5:0] == last_wd[5:0]) else $error("control readback wrong");
  a_fill_count_range: assert property (
    rd_i && addr_i == 4'h8 |=> rdata_o[15:8] <= 8'h10 && rdata_o[7:0] <= 8'h10)
    else $error("fill count above sixteen");
  a_status_fault_fixed: assert property (
    rd_i && addr_i == 4'h4 |=> rdata_o[15:8] == 8'h00 && rdata_o[3:2] == 2'b00)
    else $error("status fault bits not zero");
  a_fifo_reset_clears: assert property (
    wr_i && addr_i == 4'h7 && wdata_i[1:0] == 2'b11 ##2 rd_i && addr_i == 4'h8
    |=> rdata_o == 16'h0000) else $error("fifo reset left counts");
  c_tx_write: cover property (wr_i && addr_i == 4'h1);
  c_rx_read: cover property (rd_i && addr_i == 4'h0);
  c_line_low: cover property (sck_oe_o && !txd_o);
endmodule
bind csf_serial_port csf_serial_port_chk u_csf_serial_port_chk (.ref_clk_i, .srst_i,
  .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .txd_o, .sck_o, .sck_oe_o, .rts_n_o);
`default_nettype wire

// ===== csf_peer_model.sv
// Clocked serial peer: sends queued bytes and collects received ones
`timescale 1ns/100ps
`default_nettype none
module csf_peer_model (
  input wire logic clk_i,
  input wire logic sck_i,
  input wire logic sck_oe_i,
  input wire logic txd_i,
  output logic rxd_o
);
  logic [7:0] tx_q[$];
  logic [7:0] got_q[$];
  logic [7:0] cur = 8'h00;
  logic [7:0] rs = 8'h00;
  logic sck_d = 1'b1;
  logic oe_d = 1'b0;
  int fb = 0;
  int rb = 0;
  initial rxd_o = 1'b1;
  always @(posedge clk_i) begin
    sck_d <= sck_i;
    oe_d <= sck_oe_i;
    // Edges count only while the clock was driven in both cycles
    if (oe_d && sck_oe_i && sck_d && !sck_i) begin
      if (fb == 0) cur = (tx_q.size() > 0) ? tx_q.pop_front() : 8'h00;
      rxd_o <= cur[fb];
      fb = (fb + 1) % 8;
    end
    if (oe_d && sck_oe_i && !sck_d && sck_i) begin
      rs = {txd_i, rs[7:1]};
      rb = rb + 1;
      if (rb == 8) begin
        got_q.push_back(rs);
        rb = 0;
        rxd_o <= ~rxd_o;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb_csf_serial_port.sv
// Self-checking bench for the serial port: registers and serial traffic
`timescale 1ns/100ps
`default_nettype none
`include "csf_consts.vh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_csf_serial_port;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [15:0] rdata_o;
  logic txd_o, sck_o, sck_oe_o, rts_n_o, rxd;
  logic txi, rxi, bri, eri;
  logic ext_sck = 1'b1;
  logic ext_on = 1'b0;
  logic [15:0] v;
  int n_errors = 0;
  int compares = 0;
  int i;
  csf_serial_port u_csf_serial_port (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd),
    .txd_o(txd_o), .sck_i(ext_sck), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .rts_n_o(rts_n_o),
    .cts_n_i(1'b0), .txi_o(txi), .rxi_o(rxi), .bri_o(bri), .eri_o(eri));
  csf_peer_model u_csf_peer_model (.clk_i(ref_clk_i), .sck_i(ext_on ? ext_sck : sck_o),
    .sck_oe_i(ext_on || sck_oe_o), .txd_i(txd_o), .rxd_o(rxd));
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    `CHK($sformatf("reg %0h", a), e, d)
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wait_peer(input int n);
    int k;
    for (k = 0; k < 4000 && u_csf_peer_model.got_q.size() < n; k++) begin
      @(posedge ref_clk_i);
    end
    if (k == 4000) begin
      n_errors++;
      end_sim();
    end
  endtask
  initial begin
    repeat (50000) @(posedge ref_clk_i);
    n_errors++;
    end_sim();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    rd_chk(`CSF_OFF_BRR, 16'h00FF);
    rd_chk(`CSF_OFF_MODE, 16'h0000);
    rd_chk(`CSF_OFF_FDR, 16'h0000);
    rd_chk(4'hF, 16'h0000);
    $display("test reset_values finished");
    wr(`CSF_OFF_MODE, 16'h0003);
    rd_chk(`CSF_OFF_MODE, 16'h0003);
    wr(`CSF_OFF_CTRL, 16'h0038);
    rd_chk(`CSF_OFF_CTRL, 16'h0038);
    `CHK("requests", 4'b1000, {txi, rxi, bri, eri})
    wr(`CSF_OFF_FCR, 16'h07F8);
    rd_chk(`CSF_OFF_FCR, 16'h07F8);
    wr(`CSF_OFF_BRR, 16'h00A5);
    rd_chk(`CSF_OFF_BRR, 16'h00A5);
    wr(`CSF_OFF_PIN, 16'h00CE);
    rd_chk(`CSF_OFF_PIN, 16'h00CE);
    `CHK("txd break level", 1'b0, txd_o)
    `CHK("rts pin level", 1'b1, rts_n_o)
    wr(`CSF_OFF_PIN, 16'h0000);
    wr(`CSF_OFF_MODE, 16'h0000);
    wr(`CSF_OFF_CTRL, 16'h0000);
    wr(`CSF_OFF_FCR, 16'h0000);
    $display("test register_access finished");
    for (i = 0; i < 17; i++) begin
      wr(`CSF_OFF_TXDATA, {8'h00, 8'h40 + i[7:0]});
    end
    rd_chk(`CSF_OFF_FDR, 16'h1000);
    wr(`CSF_OFF_STAT, 16'hFFFF);
    rd(`CSF_OFF_STAT, v);
    `CHK("fault bits", 2'b00, v[3:2])
    wr(`CSF_OFF_FCR, 16'h0003);
    rd_chk(`CSF_OFF_FDR, 16'h0000);
    wr(`CSF_OFF_FCR, 16'h0000);
    $display("test tx_overflow finished");
    for (i = 0; i < 17; i++) begin
      u_csf_peer_model.tx_q.push_back(8'hC5 ^ i[7:0]);
    end
    wr(`CSF_OFF_BRR, 16'h0003);
    wr(`CSF_OFF_CTRL, 16'h0007);
    for (i = 0; i < 16; i++) begin
      wr(`CSF_OFF_TXDATA, {8'h00, 8'h30 + i[7:0]});
    end
    wait_peer(16);
    wr(`CSF_OFF_TXDATA, 16'h0040);
    wait_peer(17);
    for (i = 0; i < 17; i++) begin
      `CHK("sent byte", 8'h30 + i[7:0], u_csf_peer_model.got_q[i])
    end
    rd_chk(`CSF_OFF_FDR, 16'h0010);
    `CHK("rts at full", 1'b1, rts_n_o)
    rd(`CSF_OFF_LSR, v);
    `CHK("overrun set", 1'b1, v[0])
    wr(`CSF_OFF_LSR, 16'h0001);
    rd(`CSF_OFF_LSR, v);
    `CHK("overrun kept", 1'b1, v[0])
    for (i = 0; i < 16; i++) begin
      rd(`CSF_OFF_RXDATA, v);
      `CHK("received byte", 8'hC5 ^ i[7:0], v[7:0])
    end
    rd_chk(`CSF_OFF_FDR, 16'h0000);
    wr(`CSF_OFF_LSR, 16'h0000);
    rd(`CSF_OFF_LSR, v);
    `CHK("overrun cleared", 1'b0, v[0])
    $display("test serial_traffic finished");
    u_csf_peer_model.tx_q.push_back(8'hA6);
    wr(`CSF_OFF_CTRL, 16'h0001);
    ext_on <= 1'b1;
    for (i = 0; i < 8; i++) begin
      repeat (8) @(posedge ref_clk_i);
      ext_sck <= 1'b0;
      repeat (8) @(posedge ref_clk_i);
      ext_sck <= 1'b1;
    end
    repeat (8) @(posedge ref_clk_i);
    rd_chk(`CSF_OFF_FDR, 16'h0001);
    rd_chk(`CSF_OFF_RXDATA, 16'h00A6);
    $display("test external_clock finished");
    end_sim();
  end
endmodule
`default_nettype wire
